// ==== hw/mcsc_pkg.sv ====
package mcsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] HW_OPTION_REPORT_OFS = 8'h10;
    localparam logic [7:0] ADJ_REFERENCE_CTRL_OFS = 8'h1c;
    localparam logic [7:0] SYNC_CTRL_OFS = 8'h20;
    localparam logic [7:0] RATE_DIV_OFS = 8'h24;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int NCLK_W = 9;
    localparam int ALT_REF_BIT = 9;
    localparam int EXT_CLK_BIT = 0;
    localparam int INV_BURST_IN_BIT = 1;
    localparam int INV_BURST_OUT_BIT = 2;
    localparam int INV_UPDATE_OUT_BIT = 3;
    localparam int INV_SYNC_PIN_BIT = 4;
    localparam int QUIET_BURST_OUT_BIT = 5;
    localparam int QUIET_UPDATE_OUT_BIT = 6;
    localparam int QUIET_SYNC_PIN_BIT = 7;
    localparam int CLOCK_READY_BIT = 8;
    localparam int SYNC_CTRL_W = 8;
    localparam int RATE_DIV_W = 18;
    localparam int FW_REV_LSB = 0;
    localparam int CHAN_LSB = 16;
    localparam int FILTER_LSB = 18;
    localparam int DIFF_BIT = 20;
    localparam int CUSTOM_CLK_BIT = 21;
    localparam int HIGH_LEVEL_BIT = 23;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [9:0] ADJ_REFERENCE_CTRL_RST = 10'h000;
    localparam logic [SYNC_CTRL_W-1:0] SYNC_CTRL_RST = 8'h00;
    localparam logic [RATE_DIV_W-1:0] RATE_DIV_RST = 18'h00010;

    // ------------------------------------------------------------
    // Frequencies and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int ADJ_BASE_HZ = 16_000_000;
    localparam int NCLK_SPAN = 511;
    // Phase step per unit of (511 + count): 2^32 * 16e6 / (511 * 100e6)
    localparam logic [31:0] ADJ_STEP =
        32'((64'(ADJ_BASE_HZ) << 32) / (64'(NCLK_SPAN) * 64'(CLK_HZ)));
    localparam int MASTER_HZ = 45_000_000;
    localparam logic [31:0] MASTER_INC = 32'((64'(MASTER_HZ) << 32) / 64'(CLK_HZ));
    localparam int SETTLE_MS = 100;
    localparam int SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);
    localparam int SETTLE_W = 24;

    typedef enum logic [1:0] {
        MCSC_MASTER_OUT,
        MCSC_ADJ_OUT,
        MCSC_EXT_DIRECT,
        MCSC_EXT_REF
    } mcsc_mode_t;

endpackage : mcsc_pkg

// ==== hw/mcsc_reg_if.sv ====
`timescale 1ns/1ps
interface mcsc_reg_if;
    logic wr;
    logic [mcsc_pkg::ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport bus (output wr, output addr, output wdata, input rdata);
    modport regs (input wr, input addr, input wdata, output rdata);
endinterface : mcsc_reg_if

// ==== hw/mcsc_ahb_slave.sv ====
`timescale 1ns/1ps
module mcsc_ahb_slave
    import mcsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // AHB-Lite
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Register side
    mcsc_reg_if.bus reg_o
);

    logic dp_wr;
    logic dp_rd;
    logic [ADDR_W-1:0] dp_addr;
    logic take;

    // Only word transfers are decoded; other sizes act as no-ops
    assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);

    // ------------------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= '0;
        end
        else if (hreadyout_o)
        begin
            dp_wr <= take && hwrite_i;
            dp_rd <= take && !hwrite_i;
            if (take)
                dp_addr <= {haddr_i[ADDR_W-1:2], 2'b00};
        end
        else
        begin
            dp_rd <= 1'b0;
        end
    end

    // One wait state on reads so a preceding write is visible
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hreadyout_o <= 1'b1;
        else if (hreadyout_o)
            hreadyout_o <= !(take && !hwrite_i);
        else
            hreadyout_o <= 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hrdata_o <= '0;
        else if (dp_rd)
            hrdata_o <= reg_o.rdata;
    end

    assign hresp_o = 1'b0;
    assign reg_o.wr = dp_wr && hreadyout_o;
    assign reg_o.addr = dp_addr;
    assign reg_o.wdata = hwdata_i;

endmodule : mcsc_ahb_slave

// ==== hw/mcsc_nco.sv ====
`timescale 1ns/1ps
module mcsc_nco
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Phase step per system clock
    input wire logic [31:0] inc_i,
    // Square wave and one tick per period
    output logic wave_o,
    output logic tick_o
);

    logic [31:0] acc;
    logic [32:0] next_acc;

    assign next_acc = {1'b0, acc} + {1'b0, inc_i};

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            acc <= next_acc[31:0];
            tick_o <= next_acc[32];
        end
    end

    assign wave_o = acc[31];

endmodule : mcsc_nco

// ==== hw/mcsc_top.sv ====
`timescale 1ns/1ps
module mcsc_top
    import mcsc_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter logic [11:0] FW_REVISION = 12'h001,  // Arbitrary value
    parameter logic [1:0] CHANNEL_CODE = 2'h3,
    parameter logic [1:0] FILTER_CODE = 2'h0,
    parameter logic DIFF_OUTPUTS = 1'b1,
    parameter logic CUSTOM_CLOCK = 1'b0,
    parameter logic HIGH_LEVEL = 1'b0
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Sync clock pin
    input wire logic sync_pin_i,
    output logic sync_pin_o,
    output logic sync_pin_oe_o,
    // Burst trigger pins
    input wire logic burst_pulse_in_i,
    output logic burst_pulse_out_o,
    // Update strobe pin
    output logic update_out_o,
    // Block side
    input wire logic burst_start_i,
    output logic burst_trig_o,
    output logic update_tick_o,
    output logic clock_ready_o
);

    mcsc_reg_if reg_bus ();

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [NCLK_W-1:0] nclk;
    logic alt_ref;
    logic [SYNC_CTRL_W-1:0] sync_ctrl;
    logic [RATE_DIV_W-1:0] rate_div;
    logic [SETTLE_W-1:0] settle_cnt;
    logic ext_clk;
    logic quiet_burst_out;
    logic quiet_update_out;
    logic quiet_sync_pin;
    logic inv_burst_in;
    logic inv_burst_out;
    logic inv_update_out;
    logic inv_sync_pin;
    logic wr_adj;
    logic wr_sync;
    logic wr_rate;
    mcsc_mode_t mode;

    // Word decode shared by all write paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_adj = reg_bus.wr && hit(reg_bus.addr, ADJ_REFERENCE_CTRL_OFS);
    assign wr_sync = reg_bus.wr && hit(reg_bus.addr, SYNC_CTRL_OFS);
    assign wr_rate = reg_bus.wr && hit(reg_bus.addr, RATE_DIV_OFS);

    assign ext_clk = sync_ctrl[EXT_CLK_BIT];
    assign inv_burst_in = sync_ctrl[INV_BURST_IN_BIT];
    assign inv_burst_out = sync_ctrl[INV_BURST_OUT_BIT];
    assign inv_update_out = sync_ctrl[INV_UPDATE_OUT_BIT];
    assign inv_sync_pin = sync_ctrl[INV_SYNC_PIN_BIT];
    assign quiet_burst_out = sync_ctrl[QUIET_BURST_OUT_BIT];
    assign quiet_update_out = sync_ctrl[QUIET_UPDATE_OUT_BIT];
    assign quiet_sync_pin = sync_ctrl[QUIET_SYNC_PIN_BIT];

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            nclk <= ADJ_REFERENCE_CTRL_RST[NCLK_W-1:0];
            alt_ref <= ADJ_REFERENCE_CTRL_RST[ALT_REF_BIT];
        end
        else if (wr_adj)
        begin
            nclk <= reg_bus.wdata[NCLK_W-1:0];
            alt_ref <= reg_bus.wdata[ALT_REF_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sync_ctrl <= SYNC_CTRL_RST;
        else if (wr_sync)
            sync_ctrl <= reg_bus.wdata[SYNC_CTRL_W-1:0];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rate_div <= RATE_DIV_RST;
        else if (wr_rate)
            rate_div <= reg_bus.wdata[RATE_DIV_W-1:0];
    end

    // ------------------------------------------------------------
    // Settling delay
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            settle_cnt <= '0;
        else if (wr_adj && ext_clk && (reg_bus.wdata[NCLK_W-1:0] != nclk))
            settle_cnt <= SETTLE_W'(SETTLE_CNT);
        else if (settle_cnt != '0)
            settle_cnt <= settle_cnt - SETTLE_W'(1);
    end

    assign clock_ready_o = (settle_cnt == '0);

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb
    begin
        reg_bus.rdata = '0;
        unique case (reg_bus.addr)
            HW_OPTION_REPORT_OFS:
            begin
                reg_bus.rdata[FW_REV_LSB +: 12] = FW_REVISION;
                reg_bus.rdata[CHAN_LSB +: 2] = CHANNEL_CODE;
                reg_bus.rdata[FILTER_LSB +: 2] = FILTER_CODE;
                reg_bus.rdata[DIFF_BIT] = DIFF_OUTPUTS;
                reg_bus.rdata[CUSTOM_CLK_BIT] = CUSTOM_CLOCK;
                reg_bus.rdata[HIGH_LEVEL_BIT] = HIGH_LEVEL;
                // Bits 31..24 stay at the zero default
            end
            ADJ_REFERENCE_CTRL_OFS:
            begin
                reg_bus.rdata[NCLK_W-1:0] = nclk;
                reg_bus.rdata[ALT_REF_BIT] = alt_ref;
                // Upper bits stay zero
            end
            SYNC_CTRL_OFS:
            begin
                reg_bus.rdata[SYNC_CTRL_W-1:0] = sync_ctrl;
                reg_bus.rdata[CLOCK_READY_BIT] = clock_ready_o;
            end
            RATE_DIV_OFS:
            begin
                reg_bus.rdata[RATE_DIV_W-1:0] = rate_div;
            end
            default:
            begin
                reg_bus.rdata = '0;
            end
        endcase
    end

    mcsc_ahb_slave u_ahb
    (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .hrdata_o(hrdata_o),
        .reg_o(reg_bus.bus)
    );

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    logic [31:0] adj_inc;
    logic adj_wave;
    logic adj_tick;
    logic master_wave;
    logic master_tick;

    // Phase step for 16 MHz * (511 + n) / 511
    function automatic logic [31:0] adj_step(input logic [NCLK_W-1:0] n);
        logic [63:0] prod;
        prod = (64'(NCLK_SPAN) + 64'(n)) * 64'(ADJ_STEP);
        adj_step = prod[31:0];
    endfunction : adj_step

    assign adj_inc = adj_step(nclk);

    mcsc_nco u_adj_nco
    (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .inc_i(adj_inc),
        .wave_o(adj_wave),
        .tick_o(adj_tick)
    );

    mcsc_nco u_master_nco
    (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .inc_i(MASTER_INC),
        .wave_o(master_wave),
        .tick_o(master_tick)
    );

    always_comb
    begin
        unique case ({ext_clk, alt_ref})
            2'b00: mode = MCSC_MASTER_OUT;
            2'b01: mode = MCSC_ADJ_OUT;
            2'b10: mode = MCSC_EXT_DIRECT;
            2'b11: mode = MCSC_EXT_REF;
        endcase
    end

    // ------------------------------------------------------------
    // External sync pin input
    // ------------------------------------------------------------
    logic sync_lvl;
    logic sync_prev;
    logic sync_edge;

    // Pin input is ignored while it is being driven low
    assign sync_lvl = (sync_pin_i ^ inv_sync_pin) & ext_clk & ~quiet_sync_pin;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sync_prev <= 1'b0;
        else
            sync_prev <= sync_lvl;
    end

    assign sync_edge = sync_lvl & ~sync_prev;

    // ------------------------------------------------------------
    // Sample rate generator
    // ------------------------------------------------------------
    logic src_tick;
    logic [RATE_DIV_W-1:0] rate_cnt;
    logic rate_tick;
    logic update_evt;

    always_comb
    begin
        unique case (mode)
            MCSC_MASTER_OUT: src_tick = master_tick;
            MCSC_ADJ_OUT: src_tick = adj_tick;
            MCSC_EXT_REF: src_tick = sync_edge;
            MCSC_EXT_DIRECT: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rate_cnt <= '0;
            rate_tick <= 1'b0;
        end
        else
        begin
            rate_tick <= 1'b0;
            if (src_tick)
            begin
                // Divisors of 0 and 1 both pass every source tick
                if (rate_cnt + RATE_DIV_W'(1) >= rate_div)
                begin
                    rate_cnt <= '0;
                    rate_tick <= 1'b1;
                end
                else
                begin
                    rate_cnt <= rate_cnt + RATE_DIV_W'(1);
                end
            end
        end
    end

    assign update_evt = (mode == MCSC_EXT_DIRECT) ? sync_edge : rate_tick;

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            update_tick_o <= 1'b0;
        else
            update_tick_o <= update_evt;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            update_out_o <= 1'b0;
        else if (quiet_update_out)
            update_out_o <= 1'b0;
        else
            update_out_o <= update_evt ^ inv_update_out;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            burst_pulse_out_o <= 1'b0;
        else if (quiet_burst_out)
            burst_pulse_out_o <= 1'b0;
        else
            burst_pulse_out_o <= burst_start_i ^ inv_burst_out;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            burst_trig_o <= 1'b0;
        else
            burst_trig_o <= burst_pulse_in_i ^ inv_burst_in;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync_pin_o <= 1'b0;
            sync_pin_oe_o <= 1'b0;
        end
        else if (quiet_sync_pin)
        begin
            sync_pin_o <= 1'b0;
            sync_pin_oe_o <= 1'b1;
        end
        else if (ext_clk)
        begin
            sync_pin_o <= 1'b0;
            sync_pin_oe_o <= 1'b0;
        end
        else
        begin
            sync_pin_o <= (alt_ref ? adj_wave : master_wave) ^ inv_sync_pin;
            sync_pin_oe_o <= 1'b1;
        end
    end

endmodule : mcsc_top

// ==== bench/mcsc_monitor.sv ====
`timescale 1ns/1ps
module mcsc_monitor
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Pins and block side
    input wire logic sync_pin_i,
    input wire logic sync_pin_o,
    input wire logic sync_pin_oe_o,
    input wire logic burst_pulse_in_i,
    input wire logic burst_pulse_out_o,
    input wire logic update_out_o,
    input wire logic burst_start_i,
    input wire logic burst_trig_o,
    input wire logic update_tick_o
);
    import mcsc_pkg::*;
    logic wr_ph;
    logic [7:0] wr_a;
    logic [7:0] ctrl;
    logic alt;

    // ------------------------------------------------------------
    // Shadow of the control bits written over the bus
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_ph <= 1'b0;
            wr_a <= 8'h00;
            ctrl <= 8'h00;
            alt <= 1'b0;
        end
        else if (hready_i)
        begin
            wr_ph <= hsel_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2;
            wr_a <= haddr_i[7:0];
            if (wr_ph && wr_a == SYNC_CTRL_OFS)
                ctrl <= hwdata_i[7:0];
            if (wr_ph && wr_a == ADJ_REFERENCE_CTRL_OFS)
                alt <= hwdata_i[ALT_REF_BIT];
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_read_req;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i && hsize_i == 3'h2;
    endsequence
    sequence s_read_ans;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    a_read_wait: assert property (s_read_req |=> s_read_ans)
        else $error("read wait state wrong");
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    a_quiet_burst: assert property (ctrl[5] && $past(ctrl[5]) |-> !burst_pulse_out_o)
        else $error("quiet burst output active");
    a_quiet_update: assert property (ctrl[6] && $past(ctrl[6]) |-> !update_out_o)
        else $error("quiet update output active");
    a_quiet_sync: assert property (ctrl[7] && $past(ctrl[7]) |-> sync_pin_oe_o && !sync_pin_o)
        else $error("quiet sync pin not low");
    a_target_hiz: assert property (ctrl[0] && !ctrl[7] && $stable(ctrl) |-> !sync_pin_oe_o)
        else $error("sync pin driven as target");
    a_initiator_drive: assert property (!ctrl[0] && $stable(ctrl) && $past(resetn_i)
        |-> sync_pin_oe_o)
        else $error("sync pin not driven");
    a_burst_out: assert property (!ctrl[5] && $stable(ctrl) && $past(resetn_i)
        |-> burst_pulse_out_o == ($past(burst_start_i) ^ ctrl[2]))
        else $error("burst output mismatch");
    a_update_pol: assert property (!ctrl[6] && $stable(ctrl)
        |-> update_out_o == (update_tick_o ^ ctrl[3]))
        else $error("update strobe mismatch");
    a_burst_pulse_in: assert property ($stable(ctrl) && $past(resetn_i)
        |-> burst_trig_o == ($past(burst_pulse_in_i) ^ ctrl[1]))
        else $error("burst input polarity wrong");
    a_direct_tick: assert property (ctrl[0] && !alt && !ctrl[7] && !ctrl[4] && $rose(sync_pin_i)
        |-> ##[1:3] update_tick_o)
        else $error("no update after pin edge");
endmodule : mcsc_monitor

bind mcsc_top mcsc_monitor mcsc_monitor_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .sync_pin_i(sync_pin_i), .sync_pin_o(sync_pin_o),
    .sync_pin_oe_o(sync_pin_oe_o), .burst_pulse_in_i(burst_pulse_in_i),
    .burst_pulse_out_o(burst_pulse_out_o), .update_out_o(update_out_o),
    .burst_start_i(burst_start_i), .burst_trig_o(burst_trig_o), .update_tick_o(update_tick_o));

// ==== bench/mcsc_peer_board.sv ====
`timescale 1ns/1ps
module mcsc_peer_board
(
    // Clock
    input wire logic clk_sys_i,
    // Reference drive
    input wire logic run_i,
    output logic pin_o,
    // Observed strobe
    input wire logic update_out_i,
    output int upd_count_o
);
    int phase;
    logic upd_d;

    initial
    begin
        pin_o = 1'b0;
        phase = 0;
        upd_d = 1'b0;
        upd_count_o = 0;
    end

    // Released line shows a pattern that changes every cycle
    always @(posedge clk_sys_i)
    begin
        phase <= (phase == 2) ? 0 : phase + 1;
        if (!run_i)
            pin_o <= ~pin_o;
        else if (phase == 2)
            pin_o <= ~pin_o;
        upd_d <= update_out_i;
        if (update_out_i && !upd_d)
            upd_count_o <= upd_count_o + 1;
    end
endmodule : mcsc_peer_board

// ==== bench/tb_multiboard_clock_sync_control.sv ====
`timescale 1ns/1ps
module tb_multiboard_clock_sync_control;
    import mcsc_pkg::*;
    logic clk_sys, resetn, hsel, hwrite, hreadyout, sync_o, sync_oe, sync_wire, peer_pin;
    logic burst_in, burst_out, update_out, burst_start, burst_trig, update_tick, clock_ready;
    logic peer_run;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [2:0] prev;
    int num_errors, total_checks, cycles, peer_count, pbase;
    int cnt[3];
    int base[3];
    logic [31:0] adj_v[3] = '{32'h000, 32'h200, 32'h3ff};
    int sync_e[3] = '{450, 160, 320};
    int tick_e[3] = '{112, 40, 80};
    logic [31:0] bctl[3] = '{32'h00, 32'h04, 32'h20};
    int bexp[3] = '{3, 3, 0};

    assign sync_wire = sync_oe ? sync_o : peer_pin;

    mcsc_top #(.SETTLE_CNT(50)) mcsc_top_inst (.clk_sys_i(clk_sys), .resetn_i(resetn),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(),
        .hrdata_o(hrdata), .sync_pin_i(sync_wire), .sync_pin_o(sync_o), .sync_pin_oe_o(sync_oe),
        .burst_pulse_in_i(burst_in), .burst_pulse_out_o(burst_out), .update_out_o(update_out),
        .burst_start_i(burst_start), .burst_trig_o(burst_trig), .update_tick_o(update_tick),
        .clock_ready_o(clock_ready));

    mcsc_peer_board mcsc_peer_board_inst (.clk_sys_i(clk_sys), .run_i(peer_run),
        .pin_o(peer_pin), .update_out_i(update_out), .upd_count_o(peer_count));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (sync_wire && !prev[0]) cnt[0] <= cnt[0] + 1;
        if (update_tick) cnt[1] <= cnt[1] + 1;
        if (burst_out && !prev[2]) cnt[2] <= cnt[2] + 1;
        prev <= {burst_out, 1'b0, sync_wire};
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    task conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        total_checks++;
        if ($isunknown(got) || (tol == 0 && got !== exp) || got > exp + tol || got + tol < exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(q, exp, 0);
    endtask : rd

    task win(input int n);
        repeat (3) @(posedge clk_sys);
        base = cnt;
        pbase = peer_count;
        repeat (n) @(posedge clk_sys);
    endtask : win

    initial
    begin
        {hsel, hwrite, burst_in, burst_start, peer_run, prev} = '0;
        {htrans, haddr, hwdata} = '0;
        resetn = 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(ADJ_REFERENCE_CTRL_OFS, 32'h0);
        rd(HW_OPTION_REPORT_OFS, 32'h0013_0001);
        rd(SYNC_CTRL_OFS, 32'h100);
        rd(8'h40, 32'h0);
        ahb(1'b1, ADJ_REFERENCE_CTRL_OFS, 32'hffff_ffff);
        rd(ADJ_REFERENCE_CTRL_OFS, 32'h3ff);
        ahb(1'b1, HW_OPTION_REPORT_OFS, 32'hffff_ffff);
        rd(HW_OPTION_REPORT_OFS, 32'h0013_0001);
        ahb(1'b1, RATE_DIV_OFS, 32'h4);
        for (int i = 0; i < 3; i++)
        begin
            ahb(1'b1, ADJ_REFERENCE_CTRL_OFS, adj_v[i]);
            win(1000);
            chk(cnt[0] - base[0], sync_e[i], 3);
            chk(cnt[1] - base[1], tick_e[i], 3);
            chk(peer_count - pbase, cnt[1] - base[1], 1);
            chk(sync_oe, 1'b1, 0);
        end
        ahb(1'b1, SYNC_CTRL_OFS, 32'h02);
        peer_run <= 1'b1;
        ahb(1'b1, SYNC_CTRL_OFS, 32'h03);
        win(600);
        chk(sync_oe, 1'b0, 0);
        chk(cnt[1] - base[1], (cnt[0] - base[0]) / 4, 2);
        ahb(1'b1, ADJ_REFERENCE_CTRL_OFS, 32'h205);
        rd(SYNC_CTRL_OFS, 32'h003);
        chk(clock_ready, 1'b0, 0);
        repeat (60) @(posedge clk_sys);
        chk(clock_ready, 1'b1, 0);
        ahb(1'b1, ADJ_REFERENCE_CTRL_OFS, 32'h005);
        chk(clock_ready, 1'b1, 0);
        win(600);
        chk(cnt[1] - base[1], cnt[0] - base[0], 2);
        chk(peer_count - pbase, cnt[1] - base[1], 1);
        repeat (3) @(posedge clk_sys);
        chk(burst_trig, 1'b1, 0);
        ahb(1'b1, SYNC_CTRL_OFS, 32'he3);
        win(200);
        chk({sync_oe, sync_o}, 2'b10, 0);
        chk(peer_count - pbase, 0, 0);
        peer_run <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            ahb(1'b1, SYNC_CTRL_OFS, bctl[i]);
            win(0);
            repeat (3)
            begin
                @(posedge clk_sys);
                burst_start <= 1'b1;
                @(posedge clk_sys);
                burst_start <= 1'b0;
            end
            repeat (3) @(posedge clk_sys);
            chk(cnt[2] - base[2], bexp[i], 0);
        end
        conclude();
    end
endmodule : tb_multiboard_clock_sync_control
